// ==== logic/sbt_pkg.sv ====
/*
  sbt_pkg: register offsets, field positions, reset values and timing
  constants of the sixteen-bit timer/counter.
  Assumes a plain register port with eight-bit data.
*/
package sbt_pkg;
  // register offsets (own map)
  localparam logic [3:0] ADDR_COUNT_LOW   = 4'h0;
  localparam logic [3:0] ADDR_COUNT_HIGH  = 4'h1;
  localparam logic [3:0] ADDR_CONTROL     = 4'h2;
  localparam logic [3:0] ADDR_FLAG        = 4'h3;
  localparam logic [3:0] ADDR_ENABLE      = 4'h4;
  localparam logic [3:0] ADDR_FLAG_CLEAR  = 4'h5;
  localparam logic [3:0] ADDR_PORT_DIR    = 4'h6;
  localparam logic [3:0] ADDR_PORT_PINS   = 4'h7;
  // control register fields, mask and reset value; port direction reset; flag bit
  localparam int CTL_ON_BIT    = 0;
  localparam int CTL_CS_BIT    = 1;
  localparam int CTL_SYNC_BIT  = 2;
  localparam int CTL_OSC_BIT   = 3;
  localparam int CTL_PS_LSB    = 4;
  localparam logic [7:0] CTL_MASK     = 8'h3f;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] PORT_DIR_RESET = 2'h3;
  localparam int FLAG_OVF_BIT  = 0;
  // instruction cycle is four oscillator periods
  localparam int OSC_PER_INSTR = 4;
  localparam logic [1:0] INSTR_DIV_LAST = 2'(OSC_PER_INSTR - 1);
  localparam logic [15:0] COUNT_MAX = 16'hffff;
endpackage : sbt_pkg

// ==== logic/sbt_timer.sv ====
/*
  sbt_timer: sixteen-bit timer/counter with overflow flag, mask, on/off,
  clock source select, input prescale, special event reset and oscillator
  pin takeover.
  Assumes CLOCK is the oscillator clock and all inputs are synchronous.
*/
// Design decisions made here: the placing of the registers and the plain strobed port.
// Notes on behaviour
// - count is two eight-bit halves, both readable and writable
// - count runs up from 0000h to FFFFh then wraps to 0000h
// - wrap from maximum to zero sets the latched overflow flag
// - interrupt output raised only while overflow enable bit is set
// - control bit 1 picks timer or counter operation
// - timer operation counts each instruction cycle while switched on
// - counter operation counts rising edges of the external pin only
// - count advances only while the on bit is set, else held
// - either capture/compare unit may drive the internal reset input
// - oscillator enable forces both pins to inputs, reads give zero
// - synchronisation control bit ignored with internal clock
// - internal clock is oscillator frequency divided by four
// - two-bit prescale field divides input clock, 00 passes all
`timescale 1ns/1ns
module sbt_timer
(
  // clock and reset
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  // register port
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WRITE,
  input  wire logic       READ,
  output logic      [7:0] RDATA,
  // event and pins
  input  wire logic       EVENT_RESET_A,
  input  wire logic       EVENT_RESET_B,
  input  wire logic       EXT_CLOCK_PIN,
  input  wire logic [1:0] OSC_PINS_IN,
  output logic      [1:0] OSC_PINS_OUT,
  output logic      [1:0] OSC_PINS_OE,
  output logic            IRQ
);
  import sbt_pkg::*;

  typedef struct packed {
    logic [15:0] count;
    logic [7:0]  control;
    logic        overflow_flag;
    logic        overflow_irq_enable;
    logic [1:0]  port_direction_bits;
    logic [1:0]  port_out;
    logic [1:0]  instr_div;
    logic [2:0]  prescale_cnt;
    logic        ext_prev;
    logic [7:0]  rdata;
  } sbt_state_t;

  sbt_state_t st;
  sbt_state_t next_st;

  logic        timer_on;
  logic        clock_source_select;
  logic        osc_enable;
  logic [1:0]  input_prescale_select;
  logic        instr_tick;
  logic        ext_rise;
  logic        src_tick;
  logic        count_tick;
  logic        special_reset;
  logic [2:0]  ps_last;

  // prescale terminal count for a two-bit code: 1,2,4,8 inputs per tick
  function automatic logic [2:0] sbt_ps_last(input logic [1:0] code);
    sbt_ps_last = 3'((4'h1 << code) - 4'h1);
  endfunction : sbt_ps_last

  //////////////////////////////////////////////////////////////////////////
  // decode of control fields
  assign timer_on              = st.control[CTL_ON_BIT];
  assign clock_source_select   = st.control[CTL_CS_BIT];
  assign osc_enable            = st.control[CTL_OSC_BIT];
  assign input_prescale_select = st.control[CTL_PS_LSB +: 2];
  assign ps_last               = sbt_ps_last(input_prescale_select);
  assign special_reset         = EVENT_RESET_A | EVENT_RESET_B;
  // divide-by-four instruction cycle enable
  assign instr_tick = (st.instr_div == INSTR_DIV_LAST);
  // the pin is synchronous already, so the sync bit changes nothing here
  assign ext_rise   = EXT_CLOCK_PIN & ~st.ext_prev;
  // sync control bit has no effect on source choice
  assign src_tick   = clock_source_select ? ext_rise : instr_tick;
  // at or past the terminal count, so a smaller code written mid-run never
  // leaves the prescaler stranded above its new limit
  assign count_tick = timer_on & src_tick
                      & (st.prescale_cnt >= ps_last);

  //////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st = st;
    next_st.rdata = 8'h00;
    next_st.ext_prev = EXT_CLOCK_PIN;
    next_st.instr_div = st.instr_div + 2'h1;
    // prescaler counts source ticks only while on
    if (timer_on && src_tick)
    begin
      next_st.prescale_cnt = count_tick ? 3'h0 : st.prescale_cnt + 3'h1;
    end
    if (count_tick)
    begin
      next_st.count = st.count + 16'h0001;
      if (st.count == COUNT_MAX)
      begin
        next_st.overflow_flag = 1'b1;
      end
    end
    // software writes; a write to the count also clears the prescaler
    if (WRITE)
    begin
      unique case (ADDR)
        ADDR_COUNT_LOW:
        begin
          next_st.count[7:0] = WDATA;
          next_st.prescale_cnt = 3'h0;
        end
        ADDR_COUNT_HIGH:
        begin
          next_st.count[15:8] = WDATA;
          next_st.prescale_cnt = 3'h0;
        end
        ADDR_CONTROL:    next_st.control = WDATA & CTL_MASK;
        ADDR_ENABLE:     next_st.overflow_irq_enable = WDATA[FLAG_OVF_BIT];
        ADDR_FLAG_CLEAR:
        begin
          // an overflow in this same cycle wins over the clear
          if (WDATA[FLAG_OVF_BIT] && !(count_tick && st.count == COUNT_MAX))
          begin
            next_st.overflow_flag = 1'b0;
          end
        end
        ADDR_PORT_DIR:   next_st.port_direction_bits = WDATA[1:0];
        ADDR_PORT_PINS:  next_st.port_out = WDATA[1:0];
        default:         ;
      endcase
    end
    // special event reset beats software and counting
    if (special_reset)
    begin
      next_st.count = 16'h0000;
      next_st.prescale_cnt = 3'h0;
    end
    if (READ)
    begin
      unique case (ADDR)
        ADDR_COUNT_LOW:  next_st.rdata = st.count[7:0];
        ADDR_COUNT_HIGH: next_st.rdata = st.count[15:8];
        ADDR_CONTROL:    next_st.rdata = st.control;
        ADDR_FLAG:       next_st.rdata = {7'h00, st.overflow_flag};
        ADDR_ENABLE:     next_st.rdata = {7'h00, st.overflow_irq_enable};
        ADDR_PORT_DIR:   next_st.rdata = {6'h00, st.port_direction_bits};
        ADDR_PORT_PINS:
        begin
          next_st.rdata = osc_enable ? 8'h00
                                     : {6'h00, OSC_PINS_IN};
        end
        default:         next_st.rdata = 8'h00;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
    begin
      st <= '{count: 16'h0000, control: CONTROL_RESET,
              overflow_flag: 1'b0, overflow_irq_enable: 1'b0,
              port_direction_bits: PORT_DIR_RESET, port_out: 2'h0,
              instr_div: 2'h0, prescale_cnt: 3'h0, ext_prev: 1'b0,
              rdata: 8'h00};
    end
    else
    begin
      st <= next_st;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // outputs; direction bit 1 means input
  assign RDATA        = st.rdata;
  assign IRQ          = st.overflow_flag & st.overflow_irq_enable;
  assign OSC_PINS_OUT = st.port_out;
  assign OSC_PINS_OE  = osc_enable ? 2'h0
                                   : ~st.port_direction_bits;

  //////////////////////////////////////////////////////////////////////////
  // checks
  property p_wrap;
    @(posedge CLOCK) disable iff (!RESETN)
    (count_tick && st.count == COUNT_MAX && !special_reset && !WRITE)
      |=> (st.count == 16'h0000) && st.overflow_flag;
  endproperty
  a_wrap: assert property (p_wrap) else $error("no wrap to zero");
  property p_flag;
    @(posedge CLOCK) disable iff (!RESETN)
    (count_tick && st.count == COUNT_MAX) |=> st.overflow_flag;
  endproperty
  a_flag: assert property (p_flag) else $error("flag not set");
  property p_irq;
    @(posedge CLOCK) disable iff (!RESETN)
    (WRITE && ADDR == ADDR_ENABLE && !WDATA[FLAG_OVF_BIT]) |=> !IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not gated");
  property p_hold;
    @(posedge CLOCK) disable iff (!RESETN)
    (!timer_on && !WRITE && !special_reset) |=> $stable(st.count);
  endproperty
  a_hold: assert property (p_hold) else $error("count moved off");
  property p_inc;
    @(posedge CLOCK) disable iff (!RESETN)
    (count_tick && !WRITE && !special_reset)
      |=> st.count == $past(st.count) + 16'h0001;
  endproperty
  a_inc: assert property (p_inc) else $error("no increment");
  property p_src;
    @(posedge CLOCK) disable iff (!RESETN)
    (clock_source_select && !ext_rise) |-> !count_tick;
  endproperty
  a_src: assert property (p_src) else $error("counted no edge");
  property p_div;
    @(posedge CLOCK) disable iff (!RESETN)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick;
  endproperty
  a_div: assert property (p_div) else $error("divider off");
  property p_sreset;
    @(posedge CLOCK) disable iff (!RESETN)
    special_reset |=> st.count == 16'h0000;
  endproperty
  a_sreset: assert property (p_sreset) else $error("no clear");
  property p_osc;
    @(posedge CLOCK) disable iff (!RESETN)
    (osc_enable && READ && ADDR == ADDR_PORT_PINS) |=> RDATA == 8'h00;
  endproperty
  a_osc: assert property (p_osc) else $error("pins not zero");
  property p_ps;
    @(posedge CLOCK) disable iff (!RESETN)
    (input_prescale_select == 2'h1 && count_tick && !WRITE
     && !special_reset && !WRITE) |-> ##1 !count_tick;
  endproperty
  a_ps: assert property (p_ps) else $error("prescale off");
  // behaviour seen from the pins and the register port
  property p_irq_on;
    @(posedge CLOCK) disable iff (!RESETN)
    (WRITE && ADDR == ADDR_ENABLE && WDATA[FLAG_OVF_BIT]
     && st.overflow_flag) |=> IRQ;
  endproperty
  a_irq_on: assert property (p_irq_on) else $error("irq missing");
  property p_timer;
    @(posedge CLOCK) disable iff (!RESETN)
    (timer_on && !clock_source_select && input_prescale_select == 2'h0
     && instr_tick && !WRITE && !special_reset)
      |=> st.count == $past(st.count) + 16'h0001;
  endproperty
  a_timer: assert property (p_timer) else $error("tick lost");
  property p_ext;
    @(posedge CLOCK) disable iff (!RESETN)
    (timer_on && clock_source_select && input_prescale_select == 2'h0
     && EXT_CLOCK_PIN && !st.ext_prev && !WRITE && !special_reset)
      |=> st.count == $past(st.count) + 16'h0001;
  endproperty
  a_ext: assert property (p_ext) else $error("edge lost");
  property p_sticky;
    @(posedge CLOCK) disable iff (!RESETN)
    (st.overflow_flag
     && !(WRITE && ADDR == ADDR_FLAG_CLEAR && WDATA[FLAG_OVF_BIT]))
      |=> st.overflow_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("flag lost");
  property p_clear;
    @(posedge CLOCK) disable iff (!RESETN)
    (WRITE && ADDR == ADDR_FLAG_CLEAR && WDATA[FLAG_OVF_BIT]
     && !(count_tick && st.count == COUNT_MAX)) |=> !st.overflow_flag;
  endproperty
  a_clear: assert property (p_clear) else $error("flag stuck");
  property p_oe;
    @(posedge CLOCK) disable iff (!RESETN)
    (WRITE && ADDR == ADDR_CONTROL && WDATA[CTL_OSC_BIT])
      |=> OSC_PINS_OE == 2'h0;
  endproperty
  a_oe: assert property (p_oe) else $error("pins driven");
  property p_rsv;
    @(posedge CLOCK) disable iff (!RESETN)
    (READ && ADDR == ADDR_CONTROL) |=> RDATA[7:6] == 2'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved set");
  c_wrap: cover property (@(posedge CLOCK) disable iff (!RESETN)
    count_tick && st.count == COUNT_MAX);
  c_ext: cover property (@(posedge CLOCK) disable iff (!RESETN)
    clock_source_select && count_tick);
  c_irq: cover property (@(posedge CLOCK) disable iff (!RESETN) IRQ);
  c_sreset: cover property (@(posedge CLOCK) disable iff (!RESETN)
    special_reset);
  c_osc: cover property (@(posedge CLOCK) disable iff (!RESETN)
    osc_enable && READ && ADDR == ADDR_PORT_PINS);
endmodule : sbt_timer

// ==== tb/sbt_ext_src.sv ====
/*
  sbt_ext_src: far-side model of the external count pin and the
  oscillator pin levels.
  Assumes the bench raises RUN for each burst of count edges.
*/
`timescale 1ns/1ns
module sbt_ext_src
(
  // clock and control
  input  wire logic       CLOCK,
  input  wire logic       RESETN,
  input  wire logic       RUN,
  // pins
  output logic            EXT_PIN,
  output logic      [1:0] PIN_LEVEL
);
  logic [3:0] phase;
  ////////////////////////////////////////////////////////////////////////
  // pull network on the oscillator pins, seen once the device lets go
  assign PIN_LEVEL = 2'h2;
  // eight cycles high, eight low: slow enough that a timer-mode count
  // could never match the edge count; the pin rests low between bursts
  always_ff @(posedge CLOCK or negedge RESETN)
  begin
    if (!RESETN)
      phase <= 4'h0;
    else if (!RUN)
      phase <= 4'h0;
    else
      phase <= phase + 4'h1;
  end
  assign EXT_PIN = phase[3];
endmodule : sbt_ext_src

// ==== tb/tb_top.sv ====
/*
  tb_top: register-level tests of the sixteen-bit timer/counter.
  Assumes the far-side model and a 100 MHz clock.
*/
`timescale 1ns/1ns
module tb_top;
  import sbt_pkg::*;
  logic       clock, resetn, write, read, ev_a, ev_b, run, ext_pin, irq;
  logic [3:0] addr;
  logic [7:0] wdata, rdata, d;
  logic [1:0] pout, poe, lvl, pins;
  int         error_cnt, total_checks, edges, e;
  ////////////////////////////////////////////////////////////////////////
  // wire level: device drives where enabled, else the far side's level
  assign pins = (poe & pout) | (~poe & lvl);
  sbt_timer u_sbt_timer (.CLOCK(clock), .RESETN(resetn), .ADDR(addr),
    .WDATA(wdata), .WRITE(write), .READ(read), .RDATA(rdata),
    .EVENT_RESET_A(ev_a), .EVENT_RESET_B(ev_b), .EXT_CLOCK_PIN(ext_pin),
    .OSC_PINS_IN(pins), .OSC_PINS_OUT(pout), .OSC_PINS_OE(poe), .IRQ(irq));
  sbt_ext_src u_sbt_ext_src (.CLOCK(clock), .RESETN(resetn), .RUN(run),
    .EXT_PIN(ext_pin), .PIN_LEVEL(lvl));
  // clock and edge tally of the far-side pin
  initial
  begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge ext_pin) edges++;
  ////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock);
    addr  <= a;
    wdata <= v;
    write <= 1'b1;
    @(posedge clock);
    write <= 1'b0;
  endtask : wr
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clock);
    addr <= a;
    read <= 1'b1;
    @(posedge clock);
    read <= 1'b0;
    #1 v = rdata;
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [7:0] exp);
    rd(a, d);
    check(d, exp);
  endtask : rc
  // pins are looked at one edge on, never in the step that launches them
  task automatic pin_is(input logic [7:0] exp, input bit pick_oe);
    @(posedge clock);
    #1 check(pick_oe ? {6'h0, poe} : {7'h0, irq}, exp);
  endtask : pin_is
  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // watchdog, far beyond the eight hundred or so cycles the tests need
  initial
  begin
    #200000;
    error_cnt++;
    finish_test;
  end
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {resetn, write, read, ev_a, ev_b, run, addr, wdata} = '0;
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    rc(ADDR_CONTROL, CONTROL_RESET);
    rc(ADDR_PORT_DIR, {6'h0, PORT_DIR_RESET});
    rc(4'h9, 8'h00);
    wr(ADDR_CONTROL, 8'hc0);
    rc(ADDR_CONTROL, 8'h00);
    wr(ADDR_COUNT_LOW, 8'h5a);
    wr(ADDR_COUNT_HIGH, 8'ha5);
    repeat (20) @(posedge clock);
    rc(ADDR_COUNT_LOW, 8'h5a);
    rc(ADDR_COUNT_HIGH, 8'ha5);
    // every prescale code, sync bit set on odd codes; about 130 cycles on
    for (int ps = 0; ps < 4; ps++)
    begin
      wr(ADDR_COUNT_LOW, 8'h00);
      wr(ADDR_COUNT_HIGH, 8'h00);
      wr(ADDR_CONTROL, 8'(ps << 4) | 8'((ps & 1) << 2) | 8'h01);
      repeat (128) @(posedge clock);
      wr(ADDR_CONTROL, 8'h00);
      e = 130 / (OSC_PER_INSTR << ps);
      rd(ADDR_COUNT_LOW, d);
      check(8'(d >= e - 1 && d <= e + 1), 8'h01);
    end
    // counter mode: rising edges only
    wr(ADDR_COUNT_LOW, 8'h00);
    wr(ADDR_CONTROL, 8'h03);
    edges = 0;
    run <= 1'b1;
    repeat (80) @(posedge clock);
    run <= 1'b0;
    repeat (4) @(posedge clock);
    wr(ADDR_CONTROL, 8'h00);
    rc(ADDR_COUNT_LOW, 8'(edges));
    // wrap from ffff, flag, mask
    wr(ADDR_ENABLE, 8'h00);
    wr(ADDR_COUNT_LOW, 8'hfe);
    wr(ADDR_COUNT_HIGH, 8'hff);
    wr(ADDR_CONTROL, 8'h01);
    repeat (16) @(posedge clock);
    wr(ADDR_CONTROL, 8'h00);
    rc(ADDR_FLAG, 8'h01);
    rc(ADDR_COUNT_HIGH, 8'h00);
    pin_is(8'h00, 1'b0);
    wr(ADDR_ENABLE, 8'h01);
    pin_is(8'h01, 1'b0);
    wr(ADDR_ENABLE, 8'h00);
    pin_is(8'h00, 1'b0);
    wr(ADDR_FLAG_CLEAR, 8'h01);
    rc(ADDR_FLAG, 8'h00);
    // special event reset from either unit
    for (int i = 0; i < 2; i++)
    begin
      wr(ADDR_COUNT_LOW, 8'h34);
      wr(ADDR_COUNT_HIGH, 8'h12);
      ev_a <= (i == 0);
      ev_b <= (i == 1);
      @(posedge clock);
      {ev_a, ev_b} <= 2'h0;
      rc(ADDR_COUNT_LOW, 8'h00);
      rc(ADDR_COUNT_HIGH, 8'h00);
    end
    // pins as outputs, then taken over by the oscillator
    rc(ADDR_PORT_PINS, {6'h0, lvl});
    wr(ADDR_PORT_DIR, 8'h00);
    wr(ADDR_PORT_PINS, 8'h01);
    pin_is(8'h03, 1'b1);
    rc(ADDR_PORT_PINS, 8'h01);
    wr(ADDR_CONTROL, 8'h08);
    pin_is(8'h00, 1'b1);
    rc(ADDR_PORT_PINS, 8'h00);
    finish_test;
  end
endmodule : tb_top
